// file: srvd_analog_model.sv
// Supply comparators and wake-up sources facing srvd_top.
// Assumes the bench sets the supply in millivolts and the wake levels.
`timescale 1ns/1ps
module srvd_analog_model
#(
  parameter int HI_MV = 3500,
  parameter int LO_MV = 2200,
  parameter int LAG = 2
)
(
  // Control from the bench
  input wire logic clock_in,
  input wire logic detect_enable_in,
  input wire logic [15:0] supply_mv_in,
  input wire logic [7:0] wake_level_in,
  // Levels into the block
  output logic upper_cmp_out,
  output logic lower_cmp_out,
  output logic [7:0] wake_sources_out
);
  logic [LAG-1:0] up_q = '0;
  logic [LAG-1:0] lo_q = '0;
  logic junk_q = 1'b0;
  always @(posedge clock_in)
  begin
    junk_q <= ~junk_q;
    up_q <= {up_q[LAG-2:0], supply_mv_in > HI_MV};
    lo_q <= {lo_q[LAG-2:0], supply_mv_in < LO_MV};
  end
  // Unpowered comparators give no usable level, so they toggle
  assign upper_cmp_out = detect_enable_in ? up_q[LAG-1] : junk_q;
  assign lower_cmp_out = detect_enable_in ? lo_q[LAG-1] : ~junk_q;
  assign wake_sources_out = wake_level_in;
endmodule // srvd_analog_model

// file: srvd_cfg.svh
// Constants for the stop-recovery and voltage-detect block: register
// offsets, field positions, reset values and timing counts.
// Assumes an 8-bit register port and a 20 MHz system clock.
`ifndef SRVD_CFG_SVH
`define SRVD_CFG_SVH

// Register offsets on the 8-bit register port
`define SRVD_SMR_ADDR 8'h0B
`define SRVD_LVD_ADDR 8'h0C
`define SRVD_IRQ_ADDR 8'h0D
`define SRVD_IMR_ADDR 8'h0E
`define SRVD_STAT_ADDR 8'h10
`define SRVD_MASK_ADDR 8'h11

// Stop-recovery control fields
`define SRVD_SMR_FLAG_BIT 7
`define SRVD_SMR_POL_BIT 6
`define SRVD_SMR_DLY_BIT 5
`define SRVD_SMR_SRC_HI 4
`define SRVD_SMR_SRC_LO 2
`define SRVD_SMR_DIV_BIT 0

// Voltage-detect control fields
`define SRVD_LVD_HIGH_BIT 2
`define SRVD_LVD_LOW_BIT 1
`define SRVD_LVD_EN_BIT 0

// Interrupt request and mask bit for the low-voltage request
`define SRVD_IRQ_LOW_BIT 5

// Event status bits
`define SRVD_EV_LOW 0
`define SRVD_EV_HIGH 1
`define SRVD_EV_RECOV 2
`define SRVD_EV_VALID 3
`define SRVD_EV_W 4

// Reset values
`define SRVD_SMR_RST 8'h00
`define SRVD_LVD_RST 8'h00
`define SRVD_IRQ_RST 8'h00
`define SRVD_IMR_RST 8'h00
`define SRVD_MASK_RST 4'h0

// Timing
`define SRVD_CLK_MHZ 20
`define SRVD_SETTLE_NS 20000
`define SRVD_SETTLE_CYC ((`SRVD_SETTLE_NS * `SRVD_CLK_MHZ + 999) / 1000)
`define SRVD_PRESCALE 16

`endif

// file: srvd_chk_sva.sv
// Port checks for srvd_top.
// Assumes one clock and the synchronous reset of srvd_top.
`timescale 1ns/1ps
`include "srvd_cfg.svh"
module srvd_chk_sva
(
  // Watched ports
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic long_reset_delay_out,
  input wire logic clock_div16_out,
  input wire logic detect_enable_out,
  input wire logic high_voltage_flag_out,
  input wire logic low_voltage_flag_out,
  input wire logic low_voltage_interrupt_request_out,
  input wire logic low_voltage_service_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic [9:0] en_cnt_q;
  logic [9:0] en_cnt_d;
  // Saturating count of cycles since detection was enabled
  always_comb
    en_cnt_d = !detect_enable_out ? 10'h000 :
      (en_cnt_q == 10'h3FF) ? en_cnt_q : en_cnt_q + 10'h001;
  always_ff @(posedge clock_in)
    en_cnt_q <= sys_rst_in ? 10'h000 : en_cnt_d;
  sequence s_smr_wr;
    reg_wr_in && reg_addr_in == `SRVD_SMR_ADDR;
  endsequence
  sequence s_req_kept;
    low_voltage_interrupt_request_out &&
      !(reg_wr_in && reg_addr_in == `SRVD_IRQ_ADDR);
  endsequence
  property p_div;
    s_smr_wr |=> clock_div16_out == $past(reg_wdata_in[0]);
  endproperty
  property p_dly;
    s_smr_wr |=> long_reset_delay_out == $past(reg_wdata_in[5]);
  endproperty
  property p_off;
    !detect_enable_out && !$past(detect_enable_out) |->
      !low_voltage_flag_out && !high_voltage_flag_out;
  endproperty
  property p_settle;
    en_cnt_q != 10'h000 && en_cnt_q < 10'h190 |->
      !low_voltage_flag_out && !high_voltage_flag_out;
  endproperty
  property p_low_voltage_interrupt_request;
    low_voltage_flag_out |-> low_voltage_interrupt_request_out;
  endproperty
  property p_latch;
    s_req_kept |=> low_voltage_interrupt_request_out;
  endproperty
  property p_srv;
    low_voltage_service_out |-> $past(low_voltage_interrupt_request_out);
  endproperty
  property p_smr_rd;
    $past(reg_rd_in && reg_addr_in == `SRVD_SMR_ADDR) |->
      reg_rdata_out[6:0] == 7'h00;
  endproperty
  property p_lvd_rd;
    $past(reg_rd_in && reg_addr_in == `SRVD_LVD_ADDR) |->
      reg_rdata_out[7:3] == 5'h00;
  endproperty
  a_div: assert property (p_div) else $error("divide bit");
  a_dly: assert property (p_dly) else $error("delay bit");
  a_off: assert property (p_off) else $error("flag while off");
  a_settle: assert property (p_settle) else $error("early flag");
  a_low_voltage_interrupt_request: assert property (p_low_voltage_interrupt_request) else $error("no request");
  a_latch: assert property (p_latch) else $error("request lost");
  a_srv: assert property (p_srv) else $error("bad service");
  a_smr_rd: assert property (p_smr_rd) else $error("smr read");
  a_lvd_rd: assert property (p_lvd_rd) else $error("reserved");
endmodule // srvd_chk_sva

// file: srvd_pkg.sv
// Types shared by the stop-recovery and voltage-detect modules.
// Constants live in srvd_cfg.svh.
package srvd_pkg;

  typedef enum logic [2:0]
  {
    srvd_st_idle = 3'b001,
    srvd_st_settle = 3'b010,
    srvd_st_valid = 3'b100
  } srvd_settle_state_type;

endpackage

// file: srvd_settle_if.sv
// Handshake between the register logic and the settle timer.
// Both ends share one clock.
`timescale 1ns/1ps
interface srvd_settle_if;
  logic enable;
  logic valid;

  modport timer
  (
    input enable,
    output valid
  );

  modport ctrl
  (
    output enable,
    input valid
  );
endinterface

// file: srvd_settle_timer.sv
// Settle timer: flags become valid a fixed time after detection is enabled.
// Assumes enable is a synchronous level from the register logic.
`timescale 1ns/1ps
`include "srvd_cfg.svh"
module srvd_settle_timer
  import srvd_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  srvd_settle_if.timer tif
);
  localparam logic [9:0] SETTLE_LAST = 10'(`SRVD_SETTLE_CYC - 1);

  srvd_settle_state_type state_q;
  srvd_settle_state_type state_d;
  logic [9:0] count_q;
  logic [9:0] count_d;

  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      srvd_st_idle:
      begin
        count_d = 10'h000;
        if (tif.enable)
          state_d = srvd_st_settle;
      end
      srvd_st_settle:
      begin
        count_d = count_q + 10'h001;
        if (!tif.enable)
          state_d = srvd_st_idle;
        else if (count_q == SETTLE_LAST) // (R8)
          state_d = srvd_st_valid;
      end
      srvd_st_valid:
      begin
        if (!tif.enable)
          state_d = srvd_st_idle;
      end
      default:
      begin
        state_d = srvd_st_idle;
        count_d = 10'h000;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= srvd_st_idle;
      count_q <= 10'h000;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign tif.valid = (state_q == srvd_st_valid);
endmodule // srvd_settle_timer

// file: srvd_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
// Assumes inputs are slow levels; multi-bit words are not coherent.
`timescale 1ns/1ps
module srvd_sync
#(
  parameter int W = 1
)
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // srvd_sync

// file: srvd_tb_top.sv
// Register-level bench for srvd_top with the analog model.
// Assumes the fixed 400-cycle settle count of the design.
`timescale 1ns/1ps
`include "srvd_cfg.svh"
module srvd_tb_top;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic stop_recovered_in = 1'b0;
  logic [15:0] supply_mv = 16'h0BB8;
  logic [7:0] wake_lvl = 8'h00;
  logic [7:0] reg_rdata_out;
  logic [7:0] wake_src;
  logic up_cmp;
  logic lo_cmp;
  logic trig;
  logic dly;
  logic div;
  logic tick;
  logic den;
  logic hflag;
  logic lflag;
  logic req;
  logic srv;
  logic irq_out;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int i;
  always #25 clock_in = ~clock_in;
  srvd_top srvd_top_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .wake_sources_in(wake_src),
    .stop_recovered_in(stop_recovered_in), .recovery_trigger_out(trig),
    .long_reset_delay_out(dly), .clock_div16_out(div),
    .timer_clock_tick_out(tick), .upper_cmp_in(up_cmp),
    .lower_cmp_in(lo_cmp), .detect_enable_out(den),
    .high_voltage_flag_out(hflag), .low_voltage_flag_out(lflag),
    .low_voltage_interrupt_request_out(req),
    .low_voltage_service_out(srv), .irq_out(irq_out));
  srvd_analog_model srvd_analog_model_inst (.clock_in(clock_in),
    .detect_enable_in(den), .supply_mv_in(supply_mv),
    .wake_level_in(wake_lvl), .upper_cmp_out(up_cmp),
    .lower_cmp_out(lo_cmp), .wake_sources_out(wake_src));
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic tk_cnt(input int n, input logic [7:0] exp);
    logic [7:0] k;
    k = 8'h00;
    repeat (n)
    begin
      @(posedge clock_in);
      #1;
      k = k + {7'h00, tick};
    end
    chk(k, exp);
  endtask
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      conclude;
    end
  end
  initial
  begin
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd(`SRVD_SMR_ADDR, 8'h00);
    rd(`SRVD_LVD_ADDR, 8'h00);
    rd(8'h3C, 8'h00);
    tk_cnt(16, 8'h10);
    wr(`SRVD_SMR_ADDR, 8'h21);
    rd(`SRVD_SMR_ADDR, 8'h00);
    chk({6'h00, dly, div}, 8'h03);
    tk_cnt(160, 8'h0A);
    for (i = 0; i < 8; i++)
    begin
      @(posedge clock_in);
      wake_lvl <= 8'h01 << i;
      wr(`SRVD_SMR_ADDR, {3'b010, i[2:0], 2'b00});
      cyc(4);
      chk({7'h00, trig}, 8'h01);
      wr(`SRVD_SMR_ADDR, {3'b000, i[2:0], 2'b00});
      cyc(4);
      chk({7'h00, trig}, 8'h00);
    end
    @(posedge clock_in);
    stop_recovered_in <= 1'b1;
    cyc(5);
    stop_recovered_in <= 1'b0;
    wr(`SRVD_SMR_ADDR, 8'h00);
    rd(`SRVD_SMR_ADDR, 8'h80);
    supply_mv <= 16'h0708;
    wr(`SRVD_MASK_ADDR, 8'h01);
    wr(`SRVD_LVD_ADDR, 8'hFF);
    chk({7'h00, den}, 8'h01);
    cyc(100);
    rd(`SRVD_LVD_ADDR, 8'h01);
    cyc(320);
    rd(`SRVD_LVD_ADDR, 8'h03);
    chk({6'h00, hflag, lflag}, 8'h01);
    chk({5'h00, req, srv, irq_out}, 8'h05);
    wr(`SRVD_IMR_ADDR, 8'h20);
    cyc(2);
    chk({6'h00, srv, irq_out}, 8'h03);
    supply_mv <= 16'h0E74;
    cyc(10);
    rd(`SRVD_LVD_ADDR, 8'h05);
    chk({6'h00, hflag, lflag}, 8'h02);
    chk({7'h00, req}, 8'h01);
    rd(`SRVD_STAT_ADDR, 8'h0F);
    cyc(2);
    chk({7'h00, irq_out}, 8'h00);
    wr(`SRVD_IRQ_ADDR, 8'h00);
    cyc(2);
    chk({6'h00, req, srv}, 8'h00);
    wr(`SRVD_LVD_ADDR, 8'h00);
    cyc(4);
    rd(`SRVD_LVD_ADDR, 8'h00);
    conclude;
  end
endmodule // srvd_tb_top
bind srvd_top srvd_chk_sva srvd_chk_sva_inst (.clock_in(clock_in),
  .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .long_reset_delay_out(long_reset_delay_out),
  .clock_div16_out(clock_div16_out), .detect_enable_out(detect_enable_out),
  .high_voltage_flag_out(high_voltage_flag_out),
  .low_voltage_flag_out(low_voltage_flag_out),
  .low_voltage_interrupt_request_out(low_voltage_interrupt_request_out),
  .low_voltage_service_out(low_voltage_service_out));

// file: srvd_top.sv
// Stop-recovery control and supply voltage detection, with register port.
// Assumes sys_rst_in is the power-on reset; wake sources and comparators
// are asynchronous and are synchronised here.
// Functional notes
// (R1) Stop-recovery bit 7 is read-only, set by hardware on stop recovery, cleared only by power-on reset.
// (R2) All other stop-recovery bits are write-only and read back as zero.
// (R3) Stop-recovery bit 6 picks a low or high level of the wake source as the trigger.
// (R4) Stop-recovery bit 5 selects the reset delay after recovery.
// (R5) Stop-recovery bits 4 to 2 select the wake-up source.
// (R6) Stop-recovery bit 0 divides the system and timer clocks by sixteen.
// (R7) Voltage detection runs only while voltage-detect bit 0 is set, cleared at reset.
// (R8) The voltage flags count as valid only 20 us after detection is enabled.
// (R9) Voltage-detect bit 2 is set only while supply is above the upper threshold, zero at reset.
// (R10) Voltage-detect bit 1 is set only while supply is below the lower threshold, zero at reset.
// (R11) With detection enabled, the low-voltage flag raises request five.
// (R12) Request five latches the low-voltage condition until software or reset clears it.
// (R13) Request five is serviced only when its mask bit is set, else it is just a flag.
// (R14) Software disables detection before entering stop mode.
// (R15) Software leaves the port mode register alone while checking for low voltage.
// (R16) Software enables interrupts before enabling detection to catch power-up low voltage.
// (R17) Voltage-detect bits 7 to 3 ignore writes and read as zero.
`timescale 1ns/1ps
`include "srvd_cfg.svh"
module srvd_top
  import srvd_pkg::*;
(
  // Clock and power-on reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Stop-mode recovery side
  input wire logic [7:0] wake_sources_in,
  input wire logic stop_recovered_in,
  output logic recovery_trigger_out,
  output logic long_reset_delay_out,
  output logic clock_div16_out,
  output logic timer_clock_tick_out,
  // Analog comparators
  input wire logic upper_cmp_in,
  input wire logic lower_cmp_in,
  output logic detect_enable_out,
  output logic high_voltage_flag_out,
  output logic low_voltage_flag_out,
  // Interrupts
  output logic low_voltage_interrupt_request_out,
  output logic low_voltage_service_out,
  output logic irq_out
);

  // Address match, shared by the write and read decoders
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Synchronised inputs
  // The wake word is not coherent; only the selected bit matters
  logic [7:0] wake_s;
  logic [1:0] cmp_s;
  logic recov_s;

  srvd_sync #(.W(8)) u_sync_wake
  (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in(wake_sources_in),
    .sync_out(wake_s)
  );

  srvd_sync #(.W(3)) u_sync_misc
  (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in({stop_recovered_in, upper_cmp_in, lower_cmp_in}),
    .sync_out({recov_s, cmp_s})
  );

  // Settle timer
  srvd_settle_if sif();

  srvd_settle_timer u_settle
  (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .tif(sif)
  );

  // Control registers
  logic [6:0] smr_q;
  logic [6:0] smr_d;
  logic recov_flag_q;
  logic recov_flag_d;
  logic det_en_q;
  logic det_en_d;
  logic [`SRVD_EV_W-1:0] mask_q;
  logic [`SRVD_EV_W-1:0] mask_d;

  logic wr_smr;
  logic wr_lvd;
  logic wr_irq;
  logic wr_imr;
  logic wr_mask;

  assign sif.enable = det_en_q;

  always_comb
  begin
    wr_smr = reg_wr_in && hit(reg_addr_in, `SRVD_SMR_ADDR);
    wr_lvd = reg_wr_in && hit(reg_addr_in, `SRVD_LVD_ADDR);
    wr_irq = reg_wr_in && hit(reg_addr_in, `SRVD_IRQ_ADDR);
    wr_imr = reg_wr_in && hit(reg_addr_in, `SRVD_IMR_ADDR);
    wr_mask = reg_wr_in && hit(reg_addr_in, `SRVD_MASK_ADDR);
    smr_d = smr_q;
    if (wr_smr)
      smr_d = reg_wdata_in[6:0]; // (R2)
    // Only power-on reset clears the recovery flag; writes do not touch it
    recov_flag_d = recov_flag_q | recov_s; // (R1)
    det_en_d = det_en_q;
    if (wr_lvd)
      det_en_d = reg_wdata_in[`SRVD_LVD_EN_BIT]; // (R7) (R17)
    mask_d = mask_q;
    if (wr_mask)
      mask_d = reg_wdata_in[`SRVD_EV_W-1:0];
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      smr_q <= 7'(`SRVD_SMR_RST);
      recov_flag_q <= 1'b0;
      det_en_q <= 1'(`SRVD_LVD_RST);
      mask_q <= `SRVD_MASK_RST;
    end
    else
    begin
      smr_q <= smr_d;
      recov_flag_q <= recov_flag_d;
      det_en_q <= det_en_d;
      mask_q <= mask_d;
    end
  end

  // Voltage flags, gated until the comparators have settled
  // Unpowered comparators float, so the enable gates the flags as well
  logic high_flag_q;
  logic high_flag_d;
  logic low_flag_q;
  logic low_flag_d;

  always_comb
  begin
    high_flag_d = det_en_q && sif.valid && cmp_s[1]; // (R8) (R9)
    low_flag_d = det_en_q && sif.valid && cmp_s[0]; // (R8) (R10)
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      high_flag_q <= 1'b0;
      low_flag_q <= 1'b0;
    end
    else
    begin
      high_flag_q <= high_flag_d;
      low_flag_q <= low_flag_d;
    end
  end

  // Request five and its mask; the request follows the flag's next value
  // so both change on the same edge
  logic low_voltage_interrupt_request_q;
  logic low_voltage_interrupt_request_d;
  logic imr5_q;
  logic imr5_d;

  always_comb
  begin
    imr5_d = imr5_q;
    if (wr_imr)
      imr5_d = reg_wdata_in[`SRVD_IRQ_LOW_BIT]; // (R13)
    // Software may write the request bit either way; a pending low-voltage
    // condition wins so the event is not lost in the clearing cycle
    low_voltage_interrupt_request_d = low_voltage_interrupt_request_q;
    if (wr_irq)
      low_voltage_interrupt_request_d = reg_wdata_in[`SRVD_IRQ_LOW_BIT]; // (R12)
    if (low_flag_d)
      low_voltage_interrupt_request_d = 1'b1; // (R11) (R12)
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      low_voltage_interrupt_request_q <= 1'b0;
      imr5_q <= 1'b0;
    end
    else
    begin
      low_voltage_interrupt_request_q <= low_voltage_interrupt_request_d;
      imr5_q <= imr5_d;
    end
  end

  // Recovery trigger and clock prescaler
  logic trig_q;
  logic trig_d;
  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic tick_q;
  logic tick_d;

  always_comb
  begin
    // Polarity bit set: a high level triggers; clear: a low level
    trig_d = wake_s[smr_q[`SRVD_SMR_SRC_HI:`SRVD_SMR_SRC_LO]] // (R5)
             ^ ~smr_q[`SRVD_SMR_POL_BIT]; // (R3)
    // The prescaler runs free, so turning the divider on mid-count only
    // shifts the phase of the first tick
    pre_d = pre_q + 4'h1;
    if (smr_q[`SRVD_SMR_DIV_BIT])
      tick_d = (pre_q == 4'(`SRVD_PRESCALE - 1)); // (R6)
    else
      tick_d = 1'b1; // (R6)
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      trig_q <= 1'b0;
      pre_q <= 4'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      trig_q <= trig_d;
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end

  // Event status: sticky, cleared by reading, set wins over the clear
  logic [`SRVD_EV_W-1:0] prev_q;
  logic [`SRVD_EV_W-1:0] prev_d;
  logic [`SRVD_EV_W-1:0] stat_q;
  logic [`SRVD_EV_W-1:0] stat_d;
  logic [`SRVD_EV_W-1:0] rise;
  logic rd_stat;
  logic irq_q;
  logic irq_d;
  logic svc_q;
  logic svc_d;

  always_comb
  begin
    prev_d = {sif.valid, recov_flag_q, high_flag_q, low_flag_q};
    rise = prev_d & ~prev_q;
    // irq_out trails a flag by two cycles: one for status, one for itself
    rd_stat = reg_rd_in && hit(reg_addr_in, `SRVD_STAT_ADDR);
    stat_d = stat_q;
    if (rd_stat)
      stat_d = '0;
    stat_d = stat_d | rise;
    irq_d = |(stat_q & mask_q);
    svc_d = low_voltage_interrupt_request_q && imr5_q; // (R13)
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      prev_q <= '0;
      stat_q <= '0;
      irq_q <= 1'b0;
      svc_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
      svc_q <= svc_d;
    end
  end

  // Read port: data stands in the cycle after the strobe only
  // Write-only bits read as zero; only the status read has a side effect
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd_in)
    begin
      if (hit(reg_addr_in, `SRVD_SMR_ADDR))
        rdata_d[`SRVD_SMR_FLAG_BIT] = recov_flag_q; // (R1) (R2)
      else if (hit(reg_addr_in, `SRVD_LVD_ADDR))
      begin
        rdata_d[`SRVD_LVD_HIGH_BIT] = high_flag_q; // (R9)
        rdata_d[`SRVD_LVD_LOW_BIT] = low_flag_q; // (R10)
        rdata_d[`SRVD_LVD_EN_BIT] = det_en_q; // (R17)
      end
      else if (hit(reg_addr_in, `SRVD_IRQ_ADDR))
        rdata_d[`SRVD_IRQ_LOW_BIT] = low_voltage_interrupt_request_q;
      else if (hit(reg_addr_in, `SRVD_IMR_ADDR))
        rdata_d[`SRVD_IRQ_LOW_BIT] = imr5_q;
      else if (hit(reg_addr_in, `SRVD_STAT_ADDR))
        rdata_d[`SRVD_EV_W-1:0] = stat_q;
      else if (hit(reg_addr_in, `SRVD_MASK_ADDR))
        rdata_d[`SRVD_EV_W-1:0] = mask_q;
      else
        rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata_out = rdata_q;
  assign recovery_trigger_out = trig_q;
  assign long_reset_delay_out = smr_q[`SRVD_SMR_DLY_BIT]; // (R4)
  assign clock_div16_out = smr_q[`SRVD_SMR_DIV_BIT]; // (R6)
  assign timer_clock_tick_out = tick_q;
  assign detect_enable_out = det_en_q; // (R7)
  assign high_voltage_flag_out = high_flag_q;
  assign low_voltage_flag_out = low_flag_q;
  assign low_voltage_interrupt_request_out = low_voltage_interrupt_request_q;
  assign low_voltage_service_out = svc_q;
  assign irq_out = irq_q;
endmodule // srvd_top
